// ==== hdl/fpec_pkg.sv ====
// package: constants for the nonvolatile array program/erase controller
package fpec_pkg;
    localparam logic [15:0] ARRAY_BASE       = 16'he000;
    localparam logic [15:0] USER_LAST        = 16'hfdff;
    localparam logic [15:0] CTRL_ADDR        = 16'hfe08;
    localparam logic [15:0] PROTECT_ADDR     = 16'hff7e;
    localparam logic [15:0] VECTOR_FIRST     = 16'hffd2;
    localparam logic [15:0] VECTOR_LAST      = 16'hffff;
    localparam int          USER_BYTES       = 7680;
    localparam int          VECTOR_BYTES     = 46;
    localparam int          PAGE_BYTES       = 64;
    localparam int          ROW_BYTES        = 32;
    localparam int          ARRAY_WORDS      = 8192;
    localparam int          ADDR_W           = 13;
    // control register bit positions
    localparam int          PROG_SEL_BIT     = 0;
    localparam int          ERASE_BIT        = 1;
    localparam int          MASS_BIT         = 2;
    localparam int          HIGH_VOLT_BIT    = 3;
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [7:0]  ERASED_BYTE      = 8'hff;
    localparam logic [7:0]  PROTECT_DEFAULT  = 8'hff;
    // minimum setup from array latch to high voltage enable
    localparam int          CLK_MHZ          = 100;
    localparam int          NVS_TIME_US      = 10;
    localparam int          NVS_CYCLES       = NVS_TIME_US * CLK_MHZ;
    typedef enum logic [3:0] {
        FPEC_IDLE  = 4'b0001,
        FPEC_ARMED = 4'b0010,
        FPEC_READY = 4'b0100,
        FPEC_HV    = 4'b1000
    } fpec_state_e;
endpackage

// ==== hdl/fpec_mem.sv ====
// file: byte-wide array storage with registered read and wired-and programming
`timescale 1ns/1ps
module fpec_mem
    import fpec_pkg::*;
#(
    parameter int DEPTH = ARRAY_WORDS,
    parameter int AW    = ADDR_W
) (
    input  wire logic          i_mclk,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [7:0]    o_rdata,
    input  wire logic          i_prog,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic          i_erase_page,
    input  wire logic          i_erase_all,
    input  wire logic [AW-1:0] i_eaddr
);
    logic [7:0] cells [DEPTH];
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = cells[i_raddr];
    end

    always_ff @(posedge i_mclk) begin
        o_rdata <= next_rdata;
    end

    // erase drives cells to ones, programming can only pull ones to zeros
    always_ff @(posedge i_mclk) begin
        for (int k = 0; k < DEPTH; k++) begin
            if (i_erase_all) begin
                cells[k] <= ERASED_BYTE;
            end else if (i_erase_page && (k / PAGE_BYTES) == (int'(i_eaddr) / PAGE_BYTES)) begin
                cells[k] <= ERASED_BYTE;
            end else if (i_prog && k == int'(i_waddr)) begin
                cells[k] <= cells[k] & i_wdata;
            end
        end
    end
endmodule // fpec_mem

// ==== hdl/fpec_ctrl.sv ====
// file: program/erase controller for the on-chip nonvolatile array
`timescale 1ns/1ps
module fpec_ctrl
    import fpec_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_wdata,
    input  wire logic [7:0]  i_protect_value,
    output logic      [7:0]  o_rdata,
    output logic             o_high_voltage_enable,
    output logic             o_pump_on
);
    fpec_state_e state;
    fpec_state_e next_state;
    logic        program_select;
    logic        erase_select;
    logic        mass_select;
    logic        high_voltage_enable;
    logic        next_program_select;
    logic        next_erase_select;
    logic        next_mass_select;
    logic        next_high_voltage_enable;
    logic [15:0] target;
    logic [15:0] next_target;
    logic [9:0]  setup_count;
    logic [9:0]  next_setup_count;
    logic [7:0]  rdata;
    logic [7:0]  next_rdata;
    logic        rd_sel_mem;
    logic        next_rd_sel_mem;
    logic [7:0]  mem_rdata;
    logic [7:0]  next_read_out;

    function automatic logic in_array(input logic [15:0] a);
        in_array = (a >= ARRAY_BASE && a <= USER_LAST)
            || (a >= VECTOR_FIRST && a <= VECTOR_LAST) || a == PROTECT_ADDR;
    endfunction

    function automatic logic [15:0] protect_start(input logic [7:0] v);
        protect_start = {2'b11, v, 6'h00};
    endfunction

    wire logic        ctrl_wr   = i_wr && i_addr == CTRL_ADDR;
    wire logic        array_wr  = i_wr && in_array(i_addr);
    wire logic [15:0] pstart    = protect_start(i_protect_value);
    wire logic        all_open  = i_protect_value == PROTECT_DEFAULT;
    // mass erase is refused whenever any region is locked and mass select was stored before the high voltage write
    wire logic        protected_hit = !all_open &&
        (mass_select ? 1'b1 : target >= pstart);
    wire logic        prog_strobe   = array_wr && program_select && high_voltage_enable;
    wire logic        erase_fire    = erase_select && high_voltage_enable;

    always_comb begin
        next_state               = state;
        next_program_select      = program_select;
        next_erase_select        = erase_select;
        next_mass_select         = mass_select;
        next_high_voltage_enable = high_voltage_enable;
        next_target              = target;
        next_setup_count         = setup_count;
        if (ctrl_wr) begin
            next_mass_select = i_wdata[MASS_BIT];
            // a request for both selects keeps whichever was already set
            if (i_wdata[PROG_SEL_BIT] && i_wdata[ERASE_BIT]) begin
                next_program_select = program_select;
                next_erase_select   = erase_select;
            end else begin
                next_program_select = i_wdata[PROG_SEL_BIT] && !erase_select;
                next_erase_select   = i_wdata[ERASE_BIT] && !program_select;
            end
            if (!i_wdata[HIGH_VOLT_BIT]) begin
                next_high_voltage_enable = 1'b0;
            end else if (state == FPEC_READY && (program_select || erase_select)
                         && !protected_hit) begin
                next_high_voltage_enable = 1'b1;
            end
        end
        case (state)
            FPEC_IDLE: begin
                if (array_wr && (erase_select || program_select)) begin
                    next_target      = i_addr;
                    next_setup_count = '0;
                    next_state       = FPEC_ARMED;
                end
            end
            FPEC_ARMED: begin
                if (setup_count == 10'(NVS_CYCLES - 1)) begin
                    next_state = FPEC_READY;
                end else begin
                    next_setup_count = setup_count + 10'h001;
                end
            end
            FPEC_READY: begin
                if (high_voltage_enable) begin
                    next_state = FPEC_HV;
                end
            end
            FPEC_HV: begin
                if (!high_voltage_enable) begin
                    next_state = FPEC_IDLE;
                end
            end
            default: next_state = FPEC_IDLE;
        endcase
        // dropping both selects before the pump is on abandons the sequence
        if (!next_program_select && !next_erase_select && !high_voltage_enable) begin
            next_state = FPEC_IDLE;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state               <= FPEC_IDLE;
            program_select      <= 1'b0;
            erase_select        <= 1'b0;
            mass_select         <= 1'b0;
            high_voltage_enable <= 1'b0;
            target              <= 16'h0000;
            setup_count         <= '0;
        end else begin
            state               <= next_state;
            program_select      <= next_program_select;
            erase_select        <= next_erase_select;
            mass_select         <= next_mass_select;
            high_voltage_enable <= next_high_voltage_enable;
            target              <= next_target;
            setup_count         <= next_setup_count;
        end
    end

    // programming writes only land in the row latched at arming
    wire logic row_match = i_addr[15:5] == target[15:5];

    fpec_mem u_mem (
        .i_mclk       (i_mclk),
        .i_raddr      (i_addr[ADDR_W-1:0]),
        .o_rdata      (mem_rdata),
        .i_prog       (prog_strobe && row_match),
        .i_waddr      (i_addr[ADDR_W-1:0]),
        .i_wdata      (i_wdata),
        .i_erase_page (erase_fire && !mass_select),
        .i_erase_all  (erase_fire && mass_select),
        .i_eaddr      (target[ADDR_W-1:0])
    );

    always_comb begin
        // output register keeps o_rdata off the read mux; reads answer two edges later
        next_read_out   = rd_sel_mem ? mem_rdata : rdata;
        next_rdata      = 8'h00;
        next_rd_sel_mem = 1'b0;
        if (i_rd && i_addr == CTRL_ADDR) begin
            next_rdata[PROG_SEL_BIT]  = program_select;
            next_rdata[ERASE_BIT]     = erase_select;
            next_rdata[MASS_BIT]      = mass_select;
            next_rdata[HIGH_VOLT_BIT] = high_voltage_enable;
        end else if (i_rd && i_addr == PROTECT_ADDR) begin
            next_rdata = i_protect_value;
        end else if (i_rd && in_array(i_addr)) begin
            next_rd_sel_mem = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rdata      <= 8'h00;
            rd_sel_mem <= 1'b0;
            o_rdata    <= 8'h00;
        end else begin
            rdata      <= next_rdata;
            rd_sel_mem <= next_rd_sel_mem;
            o_rdata    <= next_read_out;
        end
    end

    assign o_high_voltage_enable = high_voltage_enable;
    assign o_pump_on             = high_voltage_enable;

    sel_excl_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        !(program_select && erase_select))
        else $error("program and erase selected together");
    hv_needs_sel_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        $rose(high_voltage_enable) |-> $past(program_select || erase_select))
        else $error("pump enabled without a select");
    hv_protect_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        $rose(high_voltage_enable) |-> !$past(protected_hit))
        else $error("pump enabled on protected range");
    hv_setup_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        $rose(high_voltage_enable) |-> $past(state) == FPEC_READY)
        else $error("pump enabled before setup time");
    arm_latch_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        (state == FPEC_IDLE && array_wr && erase_select) |=> target == $past(i_addr))
        else $error("erase target not latched");
    mass_rw_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        ctrl_wr |=> mass_select == $past(i_wdata[MASS_BIT]))
        else $error("mass select not stored");
    reset_clear_a: assert property (@(posedge i_mclk)
        i_reset |=> !program_select && !erase_select && !mass_select
                    && !high_voltage_enable)
        else $error("control not cleared by reset");
    ctrl_read_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_rd && i_addr == CTRL_ADDR) |=> ##1
            o_rdata[HIGH_VOLT_BIT] == $past(high_voltage_enable, 2))
        else $error("control readback wrong");

    cov_page_erase: cover property (@(posedge i_mclk) erase_fire && !mass_select);
    cov_mass_erase: cover property (@(posedge i_mclk) erase_fire && mass_select);
    cov_program:    cover property (@(posedge i_mclk) prog_strobe && row_match);
endmodule // fpec_ctrl

// ==== verification/fpec_cpu_model.sv ====
// cpu-side bus model issuing control and array accesses
`timescale 1ns/1ps
module fpec_cpu_model
    import fpec_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic [7:0]  i_rdata,
    output logic      [15:0] o_addr,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [7:0]  o_wdata
);
    // holds shortened: the modelled array acts in every cycle with high voltage on
    localparam int HOLD = 20;
    initial begin
        o_addr = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    // fetches never come from the array, only these bus cycles reach it
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_mclk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        // read data stands from the second edge after the request
        @(posedge i_mclk);
        #1 d = i_rdata;
    endtask
    // select, protect read, arming write, setup wait, then high voltage
    task automatic start(input logic [7:0] sel, input logic [15:0] a);
        logic [7:0] d;
        wr(CTRL_ADDR, sel);
        rd(PROTECT_ADDR, d);
        wr(a, 8'h5a);
        repeat (NVS_CYCLES + 4) @(posedge i_mclk);
        wr(CTRL_ADDR, sel | 8'h08);
        repeat (HOLD) @(posedge i_mclk);
    endtask
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        wr(a, d);
        repeat (4) @(posedge i_mclk);
    endtask
    // drop the select, hold, drop high voltage, allow read recovery
    task automatic stop();
        wr(CTRL_ADDR, 8'h08);
        repeat (HOLD) @(posedge i_mclk);
        wr(CTRL_ADDR, 8'h00);
        repeat (HOLD) @(posedge i_mclk);
    endtask
endmodule // fpec_cpu_model

// ==== verification/fpec_ctrl_tb.sv ====
// self-checking bench for the program/erase controller
`timescale 1ns/1ps
module fpec_ctrl_tb
    import fpec_pkg::*;
;
    logic        i_mclk;
    logic        i_reset;
    logic [15:0] i_addr;
    logic        i_wr;
    logic        i_rd;
    logic [7:0]  i_wdata;
    logic [7:0]  i_protect_value;
    logic [7:0]  o_rdata;
    logic        o_high_voltage_enable;
    logic        o_pump_on;
    logic [7:0]  row_data [64];
    logic [7:0]  d;
    logic [7:0]  wseq [15] = '{8'h08, 8'h01, 8'h03, 8'h00, 8'h02, 8'h03, 8'h0a, 8'h00, 8'h04,
                               8'hf0, 8'h00, 8'h01, 8'h02, 8'h02, 8'h01};
    logic [7:0]  rseq [15] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 8'h02, 8'h00, 8'h04,
                               8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'h00};
    int          n_mismatch;
    int          checks;

    initial i_mclk = 1'b0;
    always #5 i_mclk = ~i_mclk;

    fpec_ctrl u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wr(i_wr),
        .i_rd(i_rd), .i_wdata(i_wdata), .i_protect_value(i_protect_value), .o_rdata(o_rdata),
        .o_high_voltage_enable(o_high_voltage_enable), .o_pump_on(o_pump_on));
    fpec_cpu_model u_cpu (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wr(i_wr),
        .o_rd(i_rd), .o_wdata(i_wdata));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // both ends of user space and the first vector byte, then random places
    function automatic logic [15:0] pick(input int i);
        if (i == 0) return ARRAY_BASE;
        if (i == 1) return USER_LAST;
        if (i == 2) return VECTOR_FIRST;
        return ARRAY_BASE + 16'($urandom_range(USER_BYTES - 1));
    endfunction

    initial begin
        repeat (60000) @(posedge i_mclk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        n_mismatch = 0;
        checks = 0;
        i_reset = 1'b1;
        i_protect_value = PROTECT_DEFAULT;
        void'($urandom(90));
        repeat (5) @(posedge i_mclk);
        i_reset <= 1'b0;
        u_cpu.rd(CTRL_ADDR, d);
        chk(d, CTRL_RESET);
        chk({7'h00, o_pump_on}, 8'h00);
        u_cpu.rd(PROTECT_ADDR, d);
        chk(d, PROTECT_DEFAULT);
        foreach (wseq[i]) begin
            u_cpu.wr(CTRL_ADDR, wseq[i]);
            u_cpu.rd(CTRL_ADDR, d);
            chk(d, rseq[i]);
        end
        // whole-array erase, with a too-early high voltage request first
        u_cpu.wr(CTRL_ADDR, 8'h06);
        u_cpu.rd(PROTECT_ADDR, d);
        u_cpu.wr(ARRAY_BASE, 8'h00);
        u_cpu.wr(CTRL_ADDR, 8'h0e);
        u_cpu.rd(CTRL_ADDR, d);
        chk(d, 8'h06);
        u_cpu.start(8'h06, USER_LAST);
        chk({7'h00, o_pump_on}, 8'h01);
        u_cpu.rd(CTRL_ADDR, d);
        chk(d, 8'h0e);
        u_cpu.stop();
        chk({7'h00, o_high_voltage_enable}, 8'h00);
        for (int i = 0; i < 12; i++) begin
            u_cpu.rd(pick(i), d);
            chk(d, ERASED_BYTE);
        end
        // program rows e020 and e040, plus a write outside the latched row
        for (int r = 0; r < 2; r++) begin
            u_cpu.start(8'h01, 16'he020 + 16'(r * ROW_BYTES));
            for (int k = 0; k < ROW_BYTES; k++) begin
                row_data[r * ROW_BYTES + k] = 8'($urandom);
                u_cpu.prog(16'he020 + 16'(r * ROW_BYTES + k), row_data[r * ROW_BYTES + k]);
            end
            u_cpu.prog(16'he000 + 16'(r * 96), 8'h00);
            u_cpu.stop();
        end
        for (int k = 0; k < 64; k++) begin
            u_cpu.rd(16'he020 + 16'(k), d);
            chk(d, row_data[k]);
        end
        u_cpu.rd(16'he000, d);
        chk(d, ERASED_BYTE);
        u_cpu.rd(16'he060, d);
        chk(d, ERASED_BYTE);
        // page erase chosen by an address 16 bytes into the page
        u_cpu.start(8'h02, 16'he050);
        u_cpu.stop();
        for (int k = 0; k < 64; k++) begin
            u_cpu.rd(16'he020 + 16'(k), d);
            chk(d, (k < ROW_BYTES) ? row_data[k] : ERASED_BYTE);
        end
        // protection from e040 upwards
        i_protect_value <= 8'h81;
        u_cpu.rd(PROTECT_ADDR, d);
        chk(d, 8'h81);
        u_cpu.start(8'h02, 16'he040);
        chk({7'h00, o_high_voltage_enable}, 8'h00);
        u_cpu.rd(CTRL_ADDR, d);
        chk(d, 8'h02);
        u_cpu.wr(CTRL_ADDR, 8'h00);
        u_cpu.start(8'h02, 16'he000);
        chk({7'h00, o_high_voltage_enable}, 8'h01);
        u_cpu.stop();
        u_cpu.rd(16'he020, d);
        chk(d, ERASED_BYTE);
        end_of_test();
    end
endmodule // fpec_ctrl_tb
